/* bench/bpr_config_core_tb.sv */
/*
  Testbench of the phase routing configuration: register values, lock,
  routing of phases to gates, and the single-phase variant beside it.
  Assumes the host model drives the register port on falling edges.
*/
`timescale 1ns/100ps

module bpr_config_core_tb;
  import bpr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic configComplete = 1'b0;
  logic [3:0] logic1Demand = 4'h0;
  logic [3:0] logic2Demand = 4'h0;
  logic [7:0] regAddr, regWriteData, regReadData, readData1;
  logic regWriteStrobe, regReadStrobe;
  logic [1:0] gateDrive, gateDrive1, outChoice, w1, s1, w2, s2;
  int errCount = 0;
  int checkCount = 0;
  int cycleCount = 0;

  // Clock at 40 ns
  always #20 clk = ~clk;

  bpr_host_model host (.clk(clk), .regAddr(regAddr), .regWriteStrobe(regWriteStrobe),
    .regWriteData(regWriteData), .regReadStrobe(regReadStrobe), .regReadData(regReadData));

  bpr_config_core uut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWriteStrobe(regWriteStrobe), .regWriteData(regWriteData),
    .regReadStrobe(regReadStrobe), .regReadData(regReadData),
    .configComplete(configComplete), .logic1Demand(logic1Demand),
    .logic2Demand(logic2Demand), .gateDrive(gateDrive), .driverOutputChoice(outChoice),
    .logic1SpreadWidth(w1), .logic1SpreadScenario(s1), .logic2SpreadWidth(w2),
    .logic2SpreadScenario(s2));

  // Single-phase variant sharing all inputs
  bpr_config_core #(.SINGLE_PHASE(1'b1)) uut1 (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWriteStrobe(regWriteStrobe), .regWriteData(regWriteData),
    .regReadStrobe(regReadStrobe), .regReadData(readData1),
    .configComplete(configComplete), .logic1Demand(logic1Demand),
    .logic2Demand(logic2Demand), .gateDrive(gateDrive1), .driverOutputChoice(),
    .logic1SpreadWidth(), .logic1SpreadScenario(), .logic2SpreadWidth(),
    .logic2SpreadScenario());

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic completeRun();
    $display("Checks %0d, mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // All registers and an unmapped offset read zero after reset
  task automatic testReset();
    logic [7:0] addrs [7] = '{8'h01, 8'h02, 8'h0B, 8'h0C, 8'h0F, 8'h10, 8'h03};
    logic [7:0] d;
    foreach (addrs[i])
    begin
      host.readReg(addrs[i], d);
      check("reset read", d, 8'h00);
    end
    $display("test reset done");
  endtask

  // Write with reserved bits clear, read back, and watch the field outputs
  task automatic testFields();
    logic [7:0] addrs [6] = '{8'h01, 8'h02, 8'h0B, 8'h0C, 8'h0F, 8'h10};
    logic [7:0] wr [6] = '{8'h03, 8'h02, 8'h99, 8'h66, 8'h01, 8'h0B};
    logic [7:0] ex [6] = '{8'h03, 8'h02, 8'h99, 8'h66, 8'h01, 8'h0B};
    logic [7:0] d;
    foreach (addrs[i])
    begin
      host.writeReg(addrs[i], wr[i]);
      host.readReg(addrs[i], d);
      check("readback", d, ex[i]);
    end
    check("output choice", 8'(outChoice), 8'h02);
    check("spread logic1", 8'({w1, s1}), 8'h9);
    check("spread logic2", 8'({w2, s2}), 8'h6);
    host.readReg(8'h01, d);
    check("single-phase enable", readData1, 8'h01);
    host.writeReg(8'h02, 8'h01);
    check("output choice", 8'(outChoice), 8'h01);
    $display("test fields done");
  endtask

  // Writes are ignored while configuration is complete, reopen on clear
  task automatic testLock();
    logic [7:0] d;
    host.writeReg(8'h0B, 8'h0F);
    configComplete = 1'b1;
    host.writeReg(8'h0B, 8'h55);
    host.readReg(8'h0B, d);
    check("locked write", d, 8'h0F);
    configComplete = 1'b0;
    host.writeReg(8'h0B, 8'h55);
    host.readReg(8'h0B, d);
    check("reopened write", d, 8'h55);
    $display("test lock done");
  endtask

  // Sets demands, lets one edge register the gates, and compares both variants
  task automatic gateCheck(input logic [3:0] d1, input logic [3:0] d2,
    input logic [1:0] exp, input logic [1:0] exp1);
    logic1Demand = d1;
    logic2Demand = d2;
    @(negedge clk);
    check("gate drive", 8'(gateDrive), 8'(exp));
    check("single-phase gate", 8'(gateDrive1), 8'(exp1));
  endtask

  // Every logic choice and route code, then a disabled phase and driver
  task automatic testRouting();
    logic [3:0] hit;
    host.writeReg(8'h0B, 8'h0F);
    host.writeReg(8'h0C, 8'h0F);
    host.writeReg(8'h01, 8'h03);
    for (int lg = 0; lg < 2; lg++)
      for (int r = 0; r < 4; r++)
      begin
        hit = 4'h1 << r;
        host.writeReg(8'h0F, 8'(lg * 3));
        host.writeReg(8'h10, 8'(r * 5));
        gateCheck(lg ? ~hit : hit, lg ? hit : ~hit, 2'h3, 2'h1);
        gateCheck(lg ? hit : ~hit, lg ? ~hit : hit, 2'h0, 2'h0);
      end
    host.writeReg(8'h0F, 8'h00);
    host.writeReg(8'h10, 8'h00);
    host.writeReg(8'h0B, 8'h0E);
    gateCheck(4'h1, 4'h0, 2'h0, 2'h0);
    host.writeReg(8'h0B, 8'h0F);
    host.writeReg(8'h01, 8'h01);
    gateCheck(4'h1, 4'h0, 2'h1, 2'h1);
    host.writeReg(8'h01, 8'h02);
    gateCheck(4'h1, 4'h0, 2'h2, 2'h0);
    host.writeReg(8'h0F, 8'h03);
    host.writeReg(8'h0C, 8'h00);
    gateCheck(4'h0, 4'hF, 2'h0, 2'h0);
    $display("test routing done");
  endtask

  // Cycle ceiling against a hang
  always @(posedge clk)
  begin
    cycleCount++;
    if (cycleCount == 5000)
    begin
      errCount++;
      completeRun();
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    testReset();
    testFields();
    testLock();
    testRouting();
    completeRun();
  end
endmodule

/* bench/bpr_host_model.sv */
/*
  Host model: the microcontroller that writes and reads the routing
  registers through the register access port, one byte per request.
  Assumes requests are launched on the falling edge of clk.
*/
`timescale 1ns/100ps

module bpr_host_model
(
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic regWriteStrobe,
  output logic [7:0] regWriteData,
  output logic regReadStrobe,
  input wire logic [7:0] regReadData
);
  // Idle port from time zero; idle data lines show a changing pattern
  initial
  begin
    regAddr = 8'h00;
    regWriteStrobe = 1'b0;
    regWriteData = 8'h00;
    regReadStrobe = 1'b0;
  end

  // One write byte, held across the taking edge; callers keep reserved bits clear
  task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    regAddr = addr;
    regWriteData = data;
    regWriteStrobe = 1'b1;
    @(negedge clk);
    regWriteStrobe = 1'b0;
    regWriteData = ~data;
  endtask

  // One read byte, data taken once the taking edge has landed
  task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    regAddr = addr;
    regReadStrobe = 1'b1;
    @(negedge clk);
    data = regReadData;
    regReadStrobe = 1'b0;
  endtask
endmodule

/* core/bpr_config_core.sv */
/*
  Phase routing configuration of the boost controller: the six routing
  registers, their lock, the two virtual logics and the two gate routes.
  Assumes the register access port, the lock bit and the phase demands
  all come from logic on clk; reset_n is asynchronous, active low.
*/
// Contract
// - Two virtual logics, phase enables set count
// - Logic 1 phase enables at 0Bh bits 3:0
// - Logic 2 phase enables at 0Ch bits 3:0
// - Spread width 7:6, scenario 5:4 stored
// - 02h bits pick output 1 or 2
// - 0Fh bits pick internal logic 1 or 2
// - 10h two-bit codes select phases 1-4
// - Each logic gives four routable phases
// - 01h bits enable gate driver phases
// - Single-phase variant ignores driver 2 enable
// - Config done locks configuration writes
`timescale 1ns/100ps

module bpr_config_core
  import bpr_pkg::*;
#(
  parameter bit SINGLE_PHASE = 1'b0
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWriteStrobe,
  input wire logic [7:0] regWriteData,
  input wire logic regReadStrobe,
  output logic [7:0] regReadData,
  input wire logic configComplete,
  input wire logic [PHASE_COUNT-1:0] logic1Demand,
  input wire logic [PHASE_COUNT-1:0] logic2Demand,
  output logic [DRIVER_COUNT-1:0] gateDrive,
  output logic [DRIVER_COUNT-1:0] driverOutputChoice,
  output logic [SPREAD_FIELD_WIDTH-1:0] logic1SpreadWidth,
  output logic [SPREAD_FIELD_WIDTH-1:0] logic1SpreadScenario,
  output logic [SPREAD_FIELD_WIDTH-1:0] logic2SpreadWidth,
  output logic [SPREAD_FIELD_WIDTH-1:0] logic2SpreadScenario
);

  // Stored register contents, defined bits only
  logic [DRIVER_COUNT-1:0] driverActive_reg;
  logic [DRIVER_COUNT-1:0] driverOutput_reg;
  logic [7:0] logic1Cfg_reg;
  logic [7:0] logic2Cfg_reg;
  logic [DRIVER_COUNT-1:0] driverLogic_reg;
  logic [2*ROUTE_WIDTH-1:0] phaseRoute_reg;
  logic [7:0] readData_reg;

  logic [DRIVER_COUNT-1:0] driverActive_next;
  logic [7:0] readData_next;
  logic writeOk;
  logic wrActive;
  logic wrOutput;
  logic wrLogic1;
  logic wrLogic2;
  logic wrDriverLogic;
  logic wrRoute;
  logic [DRIVER_COUNT-1:0] activeMask;

  logic [PHASE_COUNT-1:0] logicDemand [LOGIC_COUNT];
  logic [PHASE_COUNT-1:0] logicOn [LOGIC_COUNT];
  logic [PHASE_COUNT-1:0] logicPhases [LOGIC_COUNT];
  logic [ROUTE_WIDTH-1:0] driverRoute [DRIVER_COUNT];

  // Write decode; the lock blocks every configuration write
  assign writeOk = regWriteStrobe & ~configComplete;
  assign wrActive = writeOk & (regAddr == GATE_DRIVER_ENABLE_ADDR);
  assign wrOutput = writeOk & (regAddr == DRIVER_OUTPUT_ASSIGN_ADDR);
  assign wrLogic1 = writeOk & (regAddr == LOGIC1_PHASE_AND_SPREAD_ADDR);
  assign wrLogic2 = writeOk & (regAddr == LOGIC2_PHASE_AND_SPREAD_ADDR);
  assign wrDriverLogic = writeOk & (regAddr == DRIVER_LOGIC_ASSIGN_ADDR);
  assign wrRoute = writeOk & (regAddr == DRIVER_PHASE_ROUTE_ADDR);

  // Driver 2 enable is held off in the single-phase variant
  assign activeMask = SINGLE_PHASE ? ~(2'(1) << DRIVER2_BIT) : '1;
  assign driverActive_next = regWriteData[DRIVER_COUNT-1:0] & activeMask;

  // Read multiplexer; reserved bits and unmapped offsets read zero
  always_comb
  begin
    readData_next = UNMAPPED_READ_VALUE;
    unique case (regAddr)
      GATE_DRIVER_ENABLE_ADDR: readData_next = {6'h00, driverActive_reg};
      DRIVER_OUTPUT_ASSIGN_ADDR: readData_next = {6'h00, driverOutput_reg};
      LOGIC1_PHASE_AND_SPREAD_ADDR: readData_next = logic1Cfg_reg;
      LOGIC2_PHASE_AND_SPREAD_ADDR: readData_next = logic2Cfg_reg;
      DRIVER_LOGIC_ASSIGN_ADDR: readData_next = {6'h00, driverLogic_reg};
      DRIVER_PHASE_ROUTE_ADDR: readData_next = {4'h0, phaseRoute_reg};
      default: readData_next = UNMAPPED_READ_VALUE;
    endcase
  end

  // Driver enable and driver-to-output registers; upper bits dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      driverActive_reg <= DRIVER_BITS_RESET;
      driverOutput_reg <= DRIVER_BITS_RESET;
    end
    else
    begin
      if (wrActive)
        driverActive_reg <= driverActive_next;
      if (wrOutput)
        driverOutput_reg <= regWriteData[DRIVER_COUNT-1:0];
    end
  end

  // Phase-and-spread registers of both logics
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      logic1Cfg_reg <= PHASE_AND_SPREAD_RESET;
      logic2Cfg_reg <= PHASE_AND_SPREAD_RESET;
    end
    else
    begin
      if (wrLogic1)
        logic1Cfg_reg <= regWriteData;
      if (wrLogic2)
        logic2Cfg_reg <= regWriteData;
    end
  end

  // Driver-to-logic and phase route registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      driverLogic_reg <= DRIVER_BITS_RESET;
      phaseRoute_reg <= PHASE_ROUTE_RESET;
    end
    else
    begin
      if (wrDriverLogic)
        driverLogic_reg <= regWriteData[DRIVER_COUNT-1:0];
      if (wrRoute)
        phaseRoute_reg <= regWriteData[2*ROUTE_WIDTH-1:0];
    end
  end

  // Read data captured on the read strobe and held
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      readData_reg <= READ_DATA_RESET;
    else if (regReadStrobe)
      readData_reg <= readData_next;
  end

  assign regReadData = readData_reg;

  // Spread spectrum fields and output association to the loops
  assign logic1SpreadWidth = logic1Cfg_reg[SPREAD_WIDTH_LSB +: SPREAD_FIELD_WIDTH];
  assign logic1SpreadScenario = logic1Cfg_reg[SPREAD_SCENARIO_LSB +: SPREAD_FIELD_WIDTH];
  assign logic2SpreadWidth = logic2Cfg_reg[SPREAD_WIDTH_LSB +: SPREAD_FIELD_WIDTH];
  assign logic2SpreadScenario = logic2Cfg_reg[SPREAD_SCENARIO_LSB +: SPREAD_FIELD_WIDTH];
  assign driverOutputChoice = driverOutput_reg;

  // Per-logic demands and phase enables
  assign logicDemand[0] = logic1Demand;
  assign logicDemand[1] = logic2Demand;
  assign logicOn[0] = logic1Cfg_reg[PHASE_ON_LSB +: PHASE_COUNT];
  assign logicOn[1] = logic2Cfg_reg[PHASE_ON_LSB +: PHASE_COUNT];
  assign driverRoute[0] = phaseRoute_reg[DRIVER1_ROUTE_LSB +: ROUTE_WIDTH];
  assign driverRoute[1] = phaseRoute_reg[DRIVER2_ROUTE_LSB +: ROUTE_WIDTH];

  // One phase gate per virtual logic
  for (genvar l = 0; l < LOGIC_COUNT; l++)
  begin : gLogic
    bpr_phase_gate #(
      .PHASES(PHASE_COUNT)
    ) uGate (
      .phaseDemand(logicDemand[l]),
      .phaseOn(logicOn[l]),
      .phaseActive(logicPhases[l])
    );
  end

  // One router per gate driver
  for (genvar d = 0; d < DRIVER_COUNT; d++)
  begin : gDriver
    bpr_driver_route uRoute (
      .clk(clk),
      .reset_n(reset_n),
      .logic1Phases(logicPhases[0]),
      .logic2Phases(logicPhases[1]),
      .logicChoice(driverLogic_reg[d]),
      .phaseRoute(driverRoute[d]),
      .driverActive(driverActive_reg[d]),
      .gateOn(gateDrive[d])
    );
  end

  property p_lock_holds;
    @(posedge clk) disable iff (!reset_n)
    (regWriteStrobe && configComplete) |=>
      $stable(logic1Cfg_reg) && $stable(logic2Cfg_reg) && $stable(phaseRoute_reg)
      && $stable(driverActive_reg) && $stable(driverOutput_reg) && $stable(driverLogic_reg);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked register changed");

  property p_logic1_on;
    @(posedge clk) disable iff (!reset_n)
    (writeOk && regAddr == LOGIC1_PHASE_AND_SPREAD_ADDR) |=>
      logic1Cfg_reg[PHASE_ON_LSB +: PHASE_COUNT] == $past(regWriteData[3:0]);
  endproperty
  a_logic1_on: assert property (p_logic1_on) else $error("logic 1 enables not stored");

  property p_logic2_on;
    @(posedge clk) disable iff (!reset_n)
    (writeOk && regAddr == LOGIC2_PHASE_AND_SPREAD_ADDR) |=>
      logic2Cfg_reg[PHASE_ON_LSB +: PHASE_COUNT] == $past(regWriteData[3:0]);
  endproperty
  a_logic2_on: assert property (p_logic2_on) else $error("logic 2 enables not stored");

  property p_spread_fields;
    @(posedge clk) disable iff (!reset_n)
    (writeOk && regAddr == LOGIC2_PHASE_AND_SPREAD_ADDR) |=>
      logic2SpreadWidth == $past(regWriteData[7:6])
      && logic2SpreadScenario == $past(regWriteData[5:4]);
  endproperty
  a_spread_fields: assert property (p_spread_fields) else $error("spread fields wrong");

  property p_output_choice;
    @(posedge clk) disable iff (!reset_n)
    (writeOk && regAddr == DRIVER_OUTPUT_ASSIGN_ADDR) |=>
      driverOutputChoice == $past(regWriteData[1:0]);
  endproperty
  a_output_choice: assert property (p_output_choice) else $error("output choice wrong");

  property p_logic_choice;
    @(posedge clk) disable iff (!reset_n)
    (writeOk && regAddr == DRIVER_LOGIC_ASSIGN_ADDR) |=>
      driverLogic_reg == $past(regWriteData[1:0]);
  endproperty
  a_logic_choice: assert property (p_logic_choice) else $error("logic choice not stored");

  // A read returns the logic choice as it stood at the strobe
  property p_logic_readback;
    @(posedge clk) disable iff (!reset_n)
    (regReadStrobe && regAddr == DRIVER_LOGIC_ASSIGN_ADDR) |=>
      regReadData == {6'h00, $past(driverLogic_reg)};
  endproperty
  a_logic_readback: assert property (p_logic_readback) else $error("logic choice readback");

  property p_route_select;
    @(posedge clk) disable iff (!reset_n)
    (!writeOk && driverActive_reg[0] && !driverLogic_reg[0]
      && logic1Cfg_reg[phaseRoute_reg[1:0]] && logic1Demand[phaseRoute_reg[1:0]]) |=> gateDrive[0];
  endproperty
  a_route_select: assert property (p_route_select) else $error("phase code not routed");

  property p_driver_enable;
    @(posedge clk) disable iff (!reset_n)
    !driverActive_reg[1] |=> !gateDrive[1];
  endproperty
  a_driver_enable: assert property (p_driver_enable) else $error("disabled driver switched");

  property p_single_phase;
    @(posedge clk) disable iff (!reset_n)
    SINGLE_PHASE |-> !driverActive_reg[DRIVER2_BIT] && !gateDrive[DRIVER2_BIT];
  endproperty
  a_single_phase: assert property (p_single_phase) else $error("driver 2 on in single variant");

  property p_phase_off;
    @(posedge clk) disable iff (!reset_n)
    (logic2Cfg_reg[PHASE_ON_LSB +: PHASE_COUNT] == 4'h0) && (driverLogic_reg == 2'h3)
      |=> gateDrive == 2'h0;
  endproperty
  a_phase_off: assert property (p_phase_off) else $error("disabled phase reached driver");

  // Logic 1 spread fields follow the write as well
  property p_logic1_spread;
    @(posedge clk) disable iff (!reset_n)
    (writeOk && regAddr == LOGIC1_PHASE_AND_SPREAD_ADDR) |=>
      logic1SpreadWidth == $past(regWriteData[7:6])
      && logic1SpreadScenario == $past(regWriteData[5:4]);
  endproperty
  a_logic1_spread: assert property (p_logic1_spread) else $error("logic 1 spread wrong");

  // Driver enables are stored; driver 2 only in the two-phase variant
  property p_driver_write;
    @(posedge clk) disable iff (!reset_n)
    (writeOk && regAddr == GATE_DRIVER_ENABLE_ADDR) |=>
      driverActive_reg[0] == $past(regWriteData[0])
      && (SINGLE_PHASE || driverActive_reg[1] == $past(regWriteData[1]));
  endproperty
  a_driver_write: assert property (p_driver_write) else $error("driver enable not stored");

  // Driver 2 follows its own route code inside logic 2
  property p_route_driver2;
    @(posedge clk) disable iff (!reset_n)
    (driverActive_reg[1] && driverLogic_reg[1] && logic2Cfg_reg[phaseRoute_reg[3:2]]
      && logic2Demand[phaseRoute_reg[3:2]]) |=> gateDrive[1];
  endproperty
  a_route_driver2: assert property (p_route_driver2) else $error("driver 2 not routed");

  // A disabled driver 1 never switches
  property p_driver1_off;
    @(posedge clk) disable iff (!reset_n)
    !driverActive_reg[0] |=> !gateDrive[0];
  endproperty
  a_driver1_off: assert property (p_driver1_off) else $error("disabled driver 1 switched");

endmodule

/* core/bpr_driver_route.sv */
/*
  Router of one gate driver: picks a logic, then one of its phases, and
  registers the gate on at the next clk edge only while the driver is enabled.
  Assumes all inputs are on clk and reset_n is asynchronous, active low.
*/
`timescale 1ns/100ps

module bpr_driver_route
  import bpr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [PHASE_COUNT-1:0] logic1Phases,
  input wire logic [PHASE_COUNT-1:0] logic2Phases,
  input wire logic logicChoice,
  input wire logic [ROUTE_WIDTH-1:0] phaseRoute,
  input wire logic driverActive,
  output logic gateOn
);

  logic [PHASE_COUNT-1:0] chosenLogic;
  logic routedPhase;
  logic gateOn_reg;
  logic gateOn_next;

  // Logic select, then phase select
  assign chosenLogic = logicChoice ? logic2Phases : logic1Phases;
  assign routedPhase = chosenLogic[phaseRoute];
  assign gateOn_next = driverActive & routedPhase;
  assign gateOn = gateOn_reg;

  // Registered gate command
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gateOn_reg <= 1'b0;
    else
      gateOn_reg <= gateOn_next;
  end

  property p_gate_cause;
    @(posedge clk) disable iff (!reset_n)
    gateOn |-> $past(driverActive) && $past(routedPhase);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate on without cause");

  property p_route_pick;
    @(posedge clk) disable iff (!reset_n)
    (driverActive && logicChoice && logic2Phases[phaseRoute]) |=> gateOn;
  endproperty
  a_route_pick: assert property (p_route_pick) else $error("logic 2 phase not routed");

endmodule

/* core/bpr_phase_gate.sv */
/*
  Phase gate of one internal virtual logic: passes each of its phase
  demands only while that phase is enabled.
  Assumes the demands come from regulation logic on the same clock.
*/
`timescale 1ns/100ps

module bpr_phase_gate
  import bpr_pkg::*;
#(
  parameter int PHASES = PHASE_COUNT
)
(
  input wire logic [PHASES-1:0] phaseDemand,
  input wire logic [PHASES-1:0] phaseOn,
  output logic [PHASES-1:0] phaseActive
);

  // A disabled phase never reaches the drivers
  assign phaseActive = phaseDemand & phaseOn;

endmodule

/* core/bpr_pkg.sv */
/*
  Package of the boost phase routing configuration block: register
  offsets, field positions and widths, and reset values.
  Assumes the register access port delivers 8-bit data and 8-bit offsets.
*/
package bpr_pkg;

  // Register offsets on the register access port
  localparam logic [7:0] GATE_DRIVER_ENABLE_ADDR = 8'h01;
  localparam logic [7:0] DRIVER_OUTPUT_ASSIGN_ADDR = 8'h02;
  localparam logic [7:0] LOGIC1_PHASE_AND_SPREAD_ADDR = 8'h0B;
  localparam logic [7:0] LOGIC2_PHASE_AND_SPREAD_ADDR = 8'h0C;
  localparam logic [7:0] DRIVER_LOGIC_ASSIGN_ADDR = 8'h0F;
  localparam logic [7:0] DRIVER_PHASE_ROUTE_ADDR = 8'h10;

  // Sizes of the phase structure
  localparam int PHASE_COUNT = 4;
  localparam int DRIVER_COUNT = 2;
  localparam int LOGIC_COUNT = 2;
  localparam int ROUTE_WIDTH = 2;

  // Field positions in the phase-and-spread registers
  localparam int PHASE_ON_LSB = 0;
  localparam int SPREAD_SCENARIO_LSB = 4;
  localparam int SPREAD_WIDTH_LSB = 6;
  localparam int SPREAD_FIELD_WIDTH = 2;

  // Field positions in the phase route register
  localparam int DRIVER1_ROUTE_LSB = 0;
  localparam int DRIVER2_ROUTE_LSB = 2;

  // Driver bit that is reserved in the single-phase variant
  localparam int DRIVER2_BIT = 1;

  // Reset values
  localparam logic [1:0] DRIVER_BITS_RESET = 2'h0;
  localparam logic [7:0] PHASE_AND_SPREAD_RESET = 8'h00;
  localparam logic [3:0] PHASE_ROUTE_RESET = 4'h0;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

endpackage
